// file: rtl/gpib_device_interface_functions.sv
`timescale 1ns/100ps
module gpib_device_interface_functions (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic [7:0] dio_n_in,
	output logic [7:0] dio_n_out,
	output logic dio_n_oe,
	input wire logic dav_n_in,
	output logic dav_n_out,
	output logic dav_n_oe,
	input wire logic nrfd_n_in,
	output logic nrfd_n_out,
	output logic nrfd_n_oe,
	input wire logic ndac_n_in,
	output logic ndac_n_out,
	output logic ndac_n_oe,
	input wire logic eoi_n_in,
	output logic eoi_n_out,
	output logic eoi_n_oe,
	input wire logic atn_n,
	input wire logic ifc_n,
	input wire logic ren_n,
	output logic srq_n_out,
	output logic srq_n_oe,
	input wire logic ext_trig_n,
	output logic keys_disabled,
	output logic out_enable,
	output logic [15:0] volt_setting,
	output logic [15:0] curr_setting,
	output logic irq
);
	// ==========================================
	// helpers
	function automatic logic hit(input logic stb, input logic [3:0] a,
		input logic [3:0] idx);
		return stb && (a == idx);
	endfunction

	// sticky flag update: a set in the clearing cycle survives
	function automatic logic [5:0] sticky(input logic [5:0] cur,
		input logic [5:0] set, input logic [5:0] clr);
		return set | (cur & ~clr);
	endfunction

	// ==========================================
	// declarations
	gpib_hs_if hs();
	logic clear_mode;
	logic ext_src;
	logic cont_init;
	logic [4:0] bus_addr;
	logic [7:0] stb_reg;
	logic [7:0] sre_reg;
	logic [7:0] rx_data;
	logic rx_eoi;
	logic rx_full;
	logic [7:0] tx_data;
	logic tx_eoi;
	logic tx_busy;
	logic [15:0] vtrig;
	logic [15:0] itrig;
	logic talker;
	logic listener;
	logic spoll;
	logic remote;
	logic lockout;
	logic next_remote;
	logic next_lockout;
	logic srq_req;
	logic ext_prev;
	logic [5:0] int_stat;
	logic [5:0] int_mask;
	logic [5:0] events;
	logic [6:0] cmd;
	logic cmd_stb;
	logic dat_stb;
	logic my_listen;
	logic my_talk;
	logic dev_clear;
	logic sw_reset;
	logic sw_trig;
	logic local_key;
	logic bus_trig;
	logic ext_trig;
	logic any_trig;
	logic ifc;
	logic data_done;
	logic [7:0] poll_byte;
	logic [7:0] status_bits;

	// ==========================================
	// handshake engine
	gpib_handshake u_hs (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.hs(hs.eng),
		.dio_n_in(dio_n_in),
		.dav_n_in(dav_n_in),
		.nrfd_n_in(nrfd_n_in),
		.ndac_n_in(ndac_n_in),
		.eoi_n_in(eoi_n_in),
		.atn_n(atn_n),
		.dio_n_out(dio_n_out),
		.dio_n_oe(dio_n_oe),
		.dav_n_out(dav_n_out),
		.dav_n_oe(dav_n_oe),
		.nrfd_n_out(nrfd_n_out),
		.nrfd_n_oe(nrfd_n_oe),
		.ndac_n_out(ndac_n_out),
		.ndac_n_oe(ndac_n_oe),
		.eoi_n_out(eoi_n_out),
		.eoi_n_oe(eoi_n_oe)
	);

	// every device takes commands; data only when addressed
	assign hs.acc_en = !atn_n || listener;
	// a full receive register holds off the talker, no byte is dropped
	assign hs.acc_ready = !atn_n || !rx_full;
	assign hs.src_en = talker && atn_n;
	assign hs.tx_req = spoll || tx_busy;
	assign hs.tx_byte = spoll ? poll_byte : tx_data;
	assign hs.tx_eoi = !spoll && tx_eoi;

	// ==========================================
	// command decode
	assign cmd = hs.rx_byte[6:0];
	assign cmd_stb = hs.rx_stb && hs.rx_atn;
	assign dat_stb = hs.rx_stb && !hs.rx_atn;
	assign my_listen = cmd_stb && (cmd == {2'b01, bus_addr});
	assign my_talk = cmd_stb && (cmd == {2'b10, bus_addr});
	assign ifc = !ifc_n;
	// parallel poll configure bytes fall through undecoded
	assign dev_clear = cmd_stb && ((cmd == gpib_dev_pkg::CMD_DCL) ||
		(listener && cmd == gpib_dev_pkg::CMD_SDC));
	assign bus_trig = cmd_stb && listener &&
		(cmd == gpib_dev_pkg::CMD_GET);
	assign sw_reset = hit(reg_wr, reg_addr, gpib_dev_pkg::REG_CTRL) &&
		reg_wdata[gpib_dev_pkg::CTRL_RST];
	assign sw_trig = hit(reg_wr, reg_addr, gpib_dev_pkg::REG_CTRL) &&
		reg_wdata[gpib_dev_pkg::CTRL_TRG];
	assign local_key = hit(reg_wr, reg_addr, gpib_dev_pkg::REG_CTRL) &&
		reg_wdata[gpib_dev_pkg::CTRL_LOCAL];
	// the pin is only armed once the host has chosen it and continuous mode
	assign ext_trig = ext_prev && !ext_trig_n && ext_src &&
		cont_init;
	assign any_trig = bus_trig || sw_trig || ext_trig;
	assign data_done = hs.tx_done && !spoll;

	// ==========================================
	// talker and listener addressing, serial poll mode
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			talker <= 1'b0;
			listener <= 1'b0;
			spoll <= 1'b0;
		end else if (clk_en) begin
			if (ifc) begin
				talker <= 1'b0;
				listener <= 1'b0;
				spoll <= 1'b0;
			end else if (cmd_stb) begin
				if (my_talk) begin
					talker <= 1'b1;
					listener <= 1'b0;
				end else if (my_listen) begin
					listener <= 1'b1;
					talker <= 1'b0;
				end else if (cmd == gpib_dev_pkg::CMD_UNT) begin
					talker <= 1'b0;
				end else if (cmd == gpib_dev_pkg::CMD_UNL) begin
					listener <= 1'b0;
				end
				if (cmd == gpib_dev_pkg::CMD_SPE)
					spoll <= 1'b1;
				else if (cmd == gpib_dev_pkg::CMD_SPD)
					spoll <= 1'b0;
			end
		end
	end

	// ==========================================
	// remote and local with lockout
	always_comb begin
		next_remote = remote;
		next_lockout = lockout;
		if (ren_n) begin
			next_remote = 1'b0;
			next_lockout = 1'b0;
		end else begin
			if (my_listen)
				next_remote = 1'b1;
			if (cmd_stb && cmd == gpib_dev_pkg::CMD_LLO)
				next_lockout = 1'b1;
			if (cmd_stb && listener && cmd == gpib_dev_pkg::CMD_GTL)
				next_remote = 1'b0;
			if (local_key && !lockout)
				next_remote = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			remote <= 1'b0;
			lockout <= 1'b0;
		end else if (clk_en) begin
			remote <= next_remote;
			lockout <= next_lockout;
		end
	end

	// panel firmware reads this to gate its keys, local key excepted
	assign keys_disabled = remote;

	// ==========================================
	// configuration written over the local port
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clear_mode <= 1'b0;
			ext_src <= 1'b0;
			cont_init <= 1'b0;
			bus_addr <= gpib_dev_pkg::ADDR_RST;
			stb_reg <= 8'h00;
			sre_reg <= 8'h00;
			vtrig <= 16'h0000;
			itrig <= 16'h0000;
			int_mask <= 6'h00;
		end else if (clk_en && reg_wr) begin
			unique case (reg_addr)
				gpib_dev_pkg::REG_CTRL: begin
					clear_mode <= reg_wdata[gpib_dev_pkg::CTRL_MODE];
					ext_src <= reg_wdata[gpib_dev_pkg::CTRL_EXT];
					cont_init <= reg_wdata[gpib_dev_pkg::CTRL_CONT];
				end
				gpib_dev_pkg::REG_ADDR: bus_addr <= reg_wdata[4:0];
				gpib_dev_pkg::REG_STB: stb_reg <= reg_wdata[7:0];
				gpib_dev_pkg::REG_SRE: sre_reg <= reg_wdata[7:0];
				gpib_dev_pkg::REG_VTRIG: vtrig <= reg_wdata;
				gpib_dev_pkg::REG_ITRIG: itrig <= reg_wdata;
				gpib_dev_pkg::REG_INT_MASK: int_mask <= reg_wdata[5:0];
				default: ;
			endcase
		end
	end

	// ==========================================
	// output settings: clear and reset first, then triggers, then writes
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			out_enable <= 1'b0;
			volt_setting <= gpib_dev_pkg::VSET_RST;
			curr_setting <= gpib_dev_pkg::ISET_RST;
		end else if (clk_en) begin
			if (dev_clear || sw_reset) begin
				out_enable <= 1'b0;
				if (!clear_mode) begin
					volt_setting <= gpib_dev_pkg::VSET_RST;
					curr_setting <= gpib_dev_pkg::ISET_RST;
				end
			end else if (any_trig) begin
				// output enable is left alone; off stays off
				volt_setting <= vtrig;
				curr_setting <= itrig;
			end else if (reg_wr) begin
				if (reg_addr == gpib_dev_pkg::REG_VSET)
					volt_setting <= reg_wdata;
				if (reg_addr == gpib_dev_pkg::REG_ISET)
					curr_setting <= reg_wdata;
				if (reg_addr == gpib_dev_pkg::REG_CTRL)
					out_enable <= reg_wdata[gpib_dev_pkg::CTRL_OUT];
			end
		end
	end

	// ==========================================
	// receive register, popped by a read of its index
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_data <= 8'h00;
			rx_eoi <= 1'b0;
			rx_full <= 1'b0;
		end else if (clk_en) begin
			if (hit(reg_rd, reg_addr, gpib_dev_pkg::REG_RX) || dev_clear)
				rx_full <= 1'b0;
			if (dat_stb) begin
				rx_data <= hs.rx_byte;
				rx_eoi <= hs.rx_eoi;
				rx_full <= 1'b1;
			end
		end
	end

	// ==========================================
	// transmit register; a write while busy is ignored
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_data <= 8'h00;
			tx_eoi <= 1'b0;
			tx_busy <= 1'b0;
		end else if (clk_en) begin
			if (data_done || dev_clear)
				tx_busy <= 1'b0;
			if (hit(reg_wr, reg_addr, gpib_dev_pkg::REG_TX) && !tx_busy) begin
				tx_data <= reg_wdata[7:0];
				tx_eoi <= reg_wdata[8];
				tx_busy <= 1'b1;
			end
		end
	end

	// ==========================================
	// service request, registered so the pin is glitch free
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			srq_req <= 1'b0;
		else if (clk_en)
			srq_req <= |(stb_reg & sre_reg & 8'hBF);
	end

	// bit six of the poll answer is the request flag itself
	assign poll_byte = {stb_reg[7], srq_req, stb_reg[5:0]};
	assign srq_n_out = 1'b0;
	assign srq_n_oe = srq_req;

	// ==========================================
	// external trigger edge; input is taken as already synchronous
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			ext_prev <= 1'b1;
		else if (clk_en)
			ext_prev <= ext_trig_n;
	end

	// ==========================================
	// interrupt status, write one to clear
	assign events = {ifc, next_remote != remote, any_trig, dev_clear,
		data_done, dat_stb};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			int_stat <= 6'h00;
		else if (clk_en)
			int_stat <= sticky(int_stat, events,
				hit(reg_wr, reg_addr, gpib_dev_pkg::REG_INT_STAT) ?
				reg_wdata[5:0] : 6'h00);
	end

	assign irq = |(int_stat & int_mask);

	// ==========================================
	// read data, valid the cycle after the strobe only
	assign status_bits = {tx_busy, rx_full, out_enable, spoll, listener,
		talker, lockout, remote};

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				unique case (reg_addr)
					gpib_dev_pkg::REG_CTRL:
						reg_rdata <= {12'h000, out_enable, cont_init, ext_src,
							clear_mode};
					gpib_dev_pkg::REG_STATUS: reg_rdata <= {8'h00, status_bits};
					gpib_dev_pkg::REG_INT_STAT: reg_rdata <= {10'h000, int_stat};
					gpib_dev_pkg::REG_INT_MASK: reg_rdata <= {10'h000, int_mask};
					gpib_dev_pkg::REG_ADDR: reg_rdata <= {11'h000, bus_addr};
					gpib_dev_pkg::REG_STB: reg_rdata <= {8'h00, poll_byte};
					gpib_dev_pkg::REG_SRE: reg_rdata <= {8'h00, sre_reg};
					gpib_dev_pkg::REG_RX: reg_rdata <= {7'h00, rx_eoi, rx_data};
					gpib_dev_pkg::REG_TX: reg_rdata <= {7'h00, tx_eoi, tx_data};
					gpib_dev_pkg::REG_VSET: reg_rdata <= volt_setting;
					gpib_dev_pkg::REG_ISET: reg_rdata <= curr_setting;
					gpib_dev_pkg::REG_VTRIG: reg_rdata <= vtrig;
					gpib_dev_pkg::REG_ITRIG: reg_rdata <= itrig;
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// file: pkg/gpib_dev_pkg.sv
package gpib_dev_pkg;
	// ==========================================
	// timing
	localparam int CLK_NS = 40;
	localparam int T1_NS = 2000;
	localparam int T1_CYC = (T1_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [5:0] T1_CNT = 6'(T1_CYC);
	// ==========================================
	// register indexes on the local port
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_INT_STAT = 4'h2;
	localparam logic [3:0] REG_INT_MASK = 4'h3;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_STB = 4'h5;
	localparam logic [3:0] REG_SRE = 4'h6;
	localparam logic [3:0] REG_RX = 4'h7;
	localparam logic [3:0] REG_TX = 4'h8;
	localparam logic [3:0] REG_VSET = 4'h9;
	localparam logic [3:0] REG_ISET = 4'hA;
	localparam logic [3:0] REG_VTRIG = 4'hB;
	localparam logic [3:0] REG_ITRIG = 4'hC;
	// ==========================================
	// control bit positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_EXT = 1;
	localparam int CTRL_CONT = 2;
	localparam int CTRL_OUT = 3;
	localparam int CTRL_RST = 4;
	localparam int CTRL_TRG = 5;
	localparam int CTRL_LOCAL = 6;
	// ==========================================
	// interrupt bit positions
	localparam int INT_RX = 0;
	localparam int INT_TX = 1;
	localparam int INT_CLR = 2;
	localparam int INT_TRG = 3;
	localparam int INT_RL = 4;
	localparam int INT_IFC = 5;
	// ==========================================
	// values after reset
	localparam logic [4:0] ADDR_RST = 5'h06;
	localparam logic [15:0] VSET_RST = 16'h0000;
	localparam logic [15:0] ISET_RST = 16'h0000;
	// ==========================================
	// bus commands, seven bits
	localparam logic [6:0] CMD_GTL = 7'h01;
	localparam logic [6:0] CMD_SDC = 7'h04;
	localparam logic [6:0] CMD_GET = 7'h08;
	localparam logic [6:0] CMD_LLO = 7'h11;
	localparam logic [6:0] CMD_DCL = 7'h14;
	localparam logic [6:0] CMD_SPE = 7'h18;
	localparam logic [6:0] CMD_SPD = 7'h19;
	localparam logic [6:0] CMD_UNL = 7'h3F;
	localparam logic [6:0] CMD_UNT = 7'h5F;
	// ==========================================
	// handshake states
	typedef enum logic [0:0] {ACC_IDLE = 1'b0, ACC_HOLD = 1'b1} acc_state_e;
	typedef enum logic [1:0] {
		SRC_IDLE = 2'b00,
		SRC_SETTLE = 2'b01,
		SRC_DAV = 2'b10,
		SRC_GAP = 2'b11
	} src_state_e;
endpackage

// file: pkg/gpib_hs_if.sv
`timescale 1ns/100ps
// ==========================================
// link between the function logic and the handshake engine
interface gpib_hs_if;
	logic acc_en;
	logic acc_ready;
	logic rx_stb;
	logic [7:0] rx_byte;
	logic rx_eoi;
	logic rx_atn;
	logic src_en;
	logic tx_req;
	logic [7:0] tx_byte;
	logic tx_eoi;
	logic tx_done;
	modport ctl (output acc_en, acc_ready, src_en, tx_req, tx_byte, tx_eoi,
		input rx_stb, rx_byte, rx_eoi, rx_atn, tx_done);
	modport eng (input acc_en, acc_ready, src_en, tx_req, tx_byte, tx_eoi,
		output rx_stb, rx_byte, rx_eoi, rx_atn, tx_done);
endinterface

// file: rtl/gpib_handshake.sv
`timescale 1ns/100ps
module gpib_handshake (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic clk_en,
	gpib_hs_if.eng hs,
	input wire logic [7:0] dio_n_in,
	input wire logic dav_n_in,
	input wire logic nrfd_n_in,
	input wire logic ndac_n_in,
	input wire logic eoi_n_in,
	input wire logic atn_n,
	output logic [7:0] dio_n_out,
	output logic dio_n_oe,
	output logic dav_n_out,
	output logic dav_n_oe,
	output logic nrfd_n_out,
	output logic nrfd_n_oe,
	output logic ndac_n_out,
	output logic ndac_n_oe,
	output logic eoi_n_out,
	output logic eoi_n_oe
);
	gpib_dev_pkg::acc_state_e acc_st;
	gpib_dev_pkg::src_state_e src_st;
	logic [5:0] settle_cnt;
	logic [7:0] tx_latch;
	logic tx_eoi_latch;
	logic src_drive;

	// ==========================================
	// acceptor: take a byte on data valid, hold until it drops
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_st <= gpib_dev_pkg::ACC_IDLE;
			hs.rx_stb <= 1'b0;
			hs.rx_byte <= 8'h00;
			hs.rx_eoi <= 1'b0;
			hs.rx_atn <= 1'b0;
		end else if (clk_en) begin
			hs.rx_stb <= 1'b0;
			unique case (acc_st)
				gpib_dev_pkg::ACC_IDLE: begin
					if (hs.acc_en && hs.acc_ready && !dav_n_in) begin
						hs.rx_byte <= ~dio_n_in;
						hs.rx_eoi <= ~eoi_n_in;
						hs.rx_atn <= ~atn_n;
						hs.rx_stb <= 1'b1;
						acc_st <= gpib_dev_pkg::ACC_HOLD;
					end
				end
				gpib_dev_pkg::ACC_HOLD: begin
					if (dav_n_in)
						acc_st <= gpib_dev_pkg::ACC_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// source: settle, raise data valid, wait for all accepted
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			src_st <= gpib_dev_pkg::SRC_IDLE;
			settle_cnt <= 6'h00;
			tx_latch <= 8'h00;
			tx_eoi_latch <= 1'b0;
			hs.tx_done <= 1'b0;
		end else if (clk_en) begin
			hs.tx_done <= 1'b0;
			unique case (src_st)
				gpib_dev_pkg::SRC_IDLE: begin
					if (hs.src_en && hs.tx_req) begin
						tx_latch <= hs.tx_byte;
						tx_eoi_latch <= hs.tx_eoi;
						settle_cnt <= gpib_dev_pkg::T1_CNT;
						src_st <= gpib_dev_pkg::SRC_SETTLE;
					end
				end
				gpib_dev_pkg::SRC_SETTLE: begin
					if (!hs.src_en)
						src_st <= gpib_dev_pkg::SRC_IDLE;
					else if (settle_cnt != 6'h00)
						settle_cnt <= settle_cnt - 6'h01;
					else if (nrfd_n_in)
						src_st <= gpib_dev_pkg::SRC_DAV;
				end
				gpib_dev_pkg::SRC_DAV: begin
					if (!hs.src_en) begin
						src_st <= gpib_dev_pkg::SRC_IDLE;
					end else if (ndac_n_in) begin
						hs.tx_done <= 1'b1;
						src_st <= gpib_dev_pkg::SRC_GAP;
					end
				end
				// one spare cycle lets the owner drop its request
				gpib_dev_pkg::SRC_GAP: src_st <= gpib_dev_pkg::SRC_IDLE;
			endcase
		end
	end

	// ==========================================
	// pin drive, control lines are only ever pulled low; data lines are driven with both levels
	assign src_drive = (src_st == gpib_dev_pkg::SRC_SETTLE) ||
		(src_st == gpib_dev_pkg::SRC_DAV);
	assign dio_n_out = ~tx_latch;
	assign dio_n_oe = src_drive;
	assign dav_n_out = 1'b0;
	assign dav_n_oe = (src_st == gpib_dev_pkg::SRC_DAV);
	assign eoi_n_out = 1'b0;
	assign eoi_n_oe = src_drive && tx_eoi_latch;
	assign ndac_n_out = 1'b0;
	assign ndac_n_oe = hs.acc_en && (acc_st == gpib_dev_pkg::ACC_IDLE);
	assign nrfd_n_out = 1'b0;
	assign nrfd_n_oe = hs.acc_en &&
		((acc_st == gpib_dev_pkg::ACC_HOLD) || !hs.acc_ready);
endmodule

// file: dv/gpib_dev_asserts.sv
`timescale 1ns/100ps
// ==========================================
// bus side checks on the device top ports
module gpib_dev_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] dio_n_out,
	input wire logic dio_n_oe,
	input wire logic dav_n_in,
	input wire logic dav_n_oe,
	input wire logic nrfd_n_in,
	input wire logic ndac_n_in,
	input wire logic ndac_n_oe,
	input wire logic eoi_n_oe,
	input wire logic atn_n,
	input wire logic ren_n,
	input wire logic srq_n_out,
	input wire logic srq_n_oe,
	input wire logic keys_disabled
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	// one cycle of atn is allowed for the source to abort
	a_no_ctl_drive: assert property (!atn_n && !$past(atn_n) |->
		!dav_n_oe && !eoi_n_oe && !dio_n_oe) else $error("drive under atn");
	a_dav_with_data: assert property (dav_n_oe |-> dio_n_oe)
		else $error("dav without data");
	a_dav_after_nrfd: assert property ($rose(dav_n_oe) |->
		$past(nrfd_n_in)) else $error("dav before ready");
	a_dav_release: assert property (dav_n_oe && ndac_n_in |=>
		!dav_n_oe) else $error("dav held after accept");
	a_data_stable: assert property (dav_n_oe && $past(dav_n_oe) |->
		$stable(dio_n_out)) else $error("data moved under dav");
	// under atn the acceptor is always enabled, so ndac ties to dav
	a_ndac_on_dav: assert property ($fell(ndac_n_oe) && !atn_n &&
		!$past(atn_n) |-> !$past(dav_n_in)) else $error("ndac early");
	a_srq_drive: assert property (srq_n_oe |-> !srq_n_out)
		else $error("srq not low");
	a_remote_ren: assert property ($rose(keys_disabled) |->
		!$past(ren_n)) else $error("remote without ren");
endmodule
bind gpib_device_interface_functions gpib_dev_asserts chk (
	.sys_clk, .rstn, .dio_n_out, .dio_n_oe, .dav_n_in, .dav_n_oe,
	.nrfd_n_in, .ndac_n_in, .ndac_n_oe, .eoi_n_oe, .atn_n, .ren_n,
	.srq_n_out, .srq_n_oe, .keys_disabled
);

// file: dv/bus_ctl_model.sv
`timescale 1ns/100ps
// ==========================================
// bus controller; released lines read high through pull-ups
module bus_ctl_model (
	input wire logic sys_clk,
	input wire logic [7:0] dio_w,
	input wire logic dav_w,
	input wire logic nrfd_w,
	input wire logic ndac_w,
	input wire logic eoi_w,
	output logic [7:0] dio_c,
	output logic dav_c,
	output logic nrfd_c,
	output logic ndac_c,
	output logic eoi_c,
	output logic atn_c,
	output logic hung
);
	// idle holds off a talker until a read is asked for
	initial begin
		dio_c = 8'hFF;
		dav_c = 1'b1;
		nrfd_c = 1'b0;
		ndac_c = 1'b0;
		eoi_c = 1'b1;
		atn_c = 1'b1;
		hung = 1'b0;
	end
	// sel 0 nrfd, 1 ndac, 2 dav; bounded so a dead link cannot hang
	task automatic wait_for(input int sel, input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((sel == 0 ? nrfd_w : sel == 1 ? ndac_w : dav_w) !== lvl
			&& n < 400);
		if (n >= 400) hung <= 1'b1;
	endtask
	// one byte as source, under atn when cmd is set
	task automatic send(input logic [7:0] b, input logic cmd, input logic e);
		atn_c <= !cmd;
		dio_c <= ~b;
		eoi_c <= !e;
		nrfd_c <= 1'b1;
		ndac_c <= 1'b1;
		wait_for(0, 1'b1);
		dav_c <= 1'b0;
		wait_for(1, 1'b1);
		dav_c <= 1'b1;
		dio_c <= 8'hFF;
		eoi_c <= 1'b1;
		nrfd_c <= 1'b0;
		ndac_c <= 1'b0;
		// one more edge so the command's effect has landed before checks
		@(posedge sys_clk);
	endtask
	// one byte as acceptor, atn released so the device may talk
	task automatic recv(output logic [7:0] b, output logic e);
		atn_c <= 1'b1;
		nrfd_c <= 1'b1;
		wait_for(2, 1'b0);
		b = ~dio_w;
		e = !eoi_w;
		nrfd_c <= 1'b0;
		ndac_c <= 1'b1;
		wait_for(2, 1'b1);
		ndac_c <= 1'b0;
	endtask
endmodule

// file: dv/test_gpib_device_interface_functions.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) begin \
			err_total++; \
			$display("[ERR] %s expected %h seen %h", nm, e, g); \
		end \
	end
module test_gpib_device_interface_functions;
	typedef struct {
		logic [3:0] a;
		logic [15:0] d;
		logic w;
		logic [15:0] e;
	} row_s;
	int err_total = 0;
	int cmp_count = 0;
	logic sys_clk, rstn, clk_en, reg_wr, reg_rd, ren_n, ifc_n, ext_trig_n;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata;
	wire [7:0] dio_n_out, dio_c;
	wire dio_n_oe, dav_n_out, dav_n_oe, nrfd_n_out, nrfd_n_oe, ndac_n_out;
	wire ndac_n_oe, eoi_n_out, eoi_n_oe, srq_n_out, srq_n_oe, irq;
	wire keys_disabled, out_enable, dav_c, nrfd_c, ndac_c, eoi_c, atn_c, hung;
	wire [15:0] reg_rdata, volt_setting, curr_setting;
	// open-collector lines: low if either side pulls
	wire [7:0] dio_w = (dio_n_oe ? dio_n_out : 8'hFF) & dio_c;
	wire dav_w = (dav_n_oe ? dav_n_out : 1'b1) & dav_c;
	wire nrfd_w = (nrfd_n_oe ? nrfd_n_out : 1'b1) & nrfd_c;
	wire ndac_w = (ndac_n_oe ? ndac_n_out : 1'b1) & ndac_c;
	wire eoi_w = (eoi_n_oe ? eoi_n_out : 1'b1) & eoi_c;
	row_s rows [9] = '{
		'{gpib_dev_pkg::REG_ADDR, 16'h0000, 1'b0, 16'h0006},
		'{gpib_dev_pkg::REG_CTRL, 16'h0000, 1'b0, 16'h0000},
		'{gpib_dev_pkg::REG_STATUS, 16'hFFFF, 1'b1, 16'h0000},
		'{4'hF, 16'hFFFF, 1'b1, 16'h0000},
		'{gpib_dev_pkg::REG_VSET, 16'h1234, 1'b1, 16'h1234},
		'{gpib_dev_pkg::REG_ISET, 16'h0056, 1'b1, 16'h0056},
		'{gpib_dev_pkg::REG_VTRIG, 16'h0ABC, 1'b1, 16'h0ABC},
		'{gpib_dev_pkg::REG_ITRIG, 16'h0011, 1'b1, 16'h0011},
		'{gpib_dev_pkg::REG_INT_MASK, 16'h003F, 1'b1, 16'h003F}
	};
	gpib_device_interface_functions DUT (
		.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .dio_n_in(dio_w), .dio_n_out, .dio_n_oe,
		.dav_n_in(dav_w), .dav_n_out, .dav_n_oe, .nrfd_n_in(nrfd_w),
		.nrfd_n_out, .nrfd_n_oe, .ndac_n_in(ndac_w), .ndac_n_out,
		.ndac_n_oe, .eoi_n_in(eoi_w), .eoi_n_out, .eoi_n_oe,
		.atn_n(atn_c), .ifc_n, .ren_n, .srq_n_out, .srq_n_oe, .ext_trig_n,
		.keys_disabled, .out_enable, .volt_setting, .curr_setting, .irq
	);
	bus_ctl_model ctl (
		.sys_clk, .dio_w, .dav_w, .nrfd_w, .ndac_w, .eoi_w, .dio_c, .dav_c,
		.nrfd_c, .ndac_c, .eoi_c, .atn_c, .hung
	);
	// ==========================================
	// clock and run control
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// a stuck handshake ends the run as a failure
	always @(posedge hung) begin
		err_total++;
		tally_and_finish();
	end
	// ==========================================
	// register port; the idle edge lets results land before checks
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		// data stand only in the cycle after the strobe; take them mid-cycle
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic rchk(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		`CHK("reg", e, d)
	endtask
	// ==========================================
	// main sequence
	initial begin
		logic [15:0] d;
		logic [7:0] b;
		logic e;
		rstn = 1'b0;
		clk_en = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		ren_n = 1'b1;
		ifc_n = 1'b1;
		ext_trig_n = 1'b1;
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			rchk(rows[i].a, rows[i].e);
		end
		wr(gpib_dev_pkg::REG_CTRL, 16'h0008);
		ctl.send(8'h14, 1'b1, 1'b0);
		`CHK("out", 1'b0, out_enable)
		`CHK("irq", 1'b1, irq)
		wr(gpib_dev_pkg::REG_CTRL, 16'h0008);
		`CHK("volt", 16'h0000, volt_setting)
		`CHK("curr", gpib_dev_pkg::ISET_RST, curr_setting)
		wr(gpib_dev_pkg::REG_VSET, 16'h1234);
		wr(gpib_dev_pkg::REG_CTRL, 16'h0009);
		ctl.send(8'h26, 1'b1, 1'b0);
		ctl.send(8'h04, 1'b1, 1'b0);
		`CHK("out", 1'b0, out_enable)
		`CHK("volt", 16'h1234, volt_setting)
		wr(gpib_dev_pkg::REG_CTRL, 16'h0019);
		`CHK("volt", 16'h1234, volt_setting)
		wr(gpib_dev_pkg::REG_CTRL, 16'h0000);
		wr(gpib_dev_pkg::REG_CTRL, 16'h0010);
		`CHK("volt", 16'h0000, volt_setting)
		// source and continuous set first, as the host must; output is set too
		wr(gpib_dev_pkg::REG_CTRL, 16'h000E);
		ext_trig_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		ext_trig_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		`CHK("volt", 16'h0ABC, volt_setting)
		`CHK("curr", 16'h0011, curr_setting)
		wr(gpib_dev_pkg::REG_INT_STAT, 16'hFFFF);
		`CHK("irq", 1'b0, irq)
		wr(gpib_dev_pkg::REG_INT_MASK, 16'h0000);
		ctl.send(8'h08, 1'b1, 1'b0);
		rd(gpib_dev_pkg::REG_INT_STAT, d);
		`CHK("get", 1'b1, d[3])
		`CHK("irq", 1'b0, irq)
		wr(gpib_dev_pkg::REG_INT_MASK, 16'h0008);
		`CHK("irq", 1'b1, irq)
		wr(gpib_dev_pkg::REG_INT_STAT, 16'hFFFF);
		wr(gpib_dev_pkg::REG_CTRL, 16'h0020);
		rd(gpib_dev_pkg::REG_INT_STAT, d);
		`CHK("trg", 1'b1, d[3])
		ren_n <= 1'b0;
		ctl.send(8'h26, 1'b1, 1'b0);
		`CHK("rmt", 1'b1, keys_disabled)
		wr(gpib_dev_pkg::REG_CTRL, 16'h0040);
		`CHK("rmt", 1'b0, keys_disabled)
		ctl.send(8'h26, 1'b1, 1'b0);
		ctl.send(8'h11, 1'b1, 1'b0);
		wr(gpib_dev_pkg::REG_CTRL, 16'h0040);
		`CHK("rmt", 1'b1, keys_disabled)
		ctl.send(8'h01, 1'b1, 1'b0);
		`CHK("rmt", 1'b0, keys_disabled)
		ctl.send(8'h41, 1'b0, 1'b1);
		rchk(gpib_dev_pkg::REG_RX, 16'h0141);
		ctl.send(8'h46, 1'b1, 1'b0);
		rd(gpib_dev_pkg::REG_STATUS, d);
		`CHK("addr", 2'b01, d[3:2])
		ctl.send(8'h26, 1'b1, 1'b0);
		rd(gpib_dev_pkg::REG_STATUS, d);
		`CHK("addr", 2'b10, d[3:2])
		ctl.send(8'h46, 1'b1, 1'b0);
		wr(gpib_dev_pkg::REG_TX, 16'h0155);
		ctl.recv(b, e);
		`CHK("tx", 8'h55, b)
		`CHK("end", 1'b1, e)
		wr(gpib_dev_pkg::REG_SRE, 16'h0001);
		wr(gpib_dev_pkg::REG_STB, 16'h0001);
		@(posedge sys_clk);
		`CHK("srq", 1'b1, srq_n_oe)
		ctl.send(8'h18, 1'b1, 1'b0);
		ctl.send(8'h46, 1'b1, 1'b0);
		ctl.recv(b, e);
		`CHK("poll", 8'h41, b)
		ctl.send(8'h19, 1'b1, 1'b0);
		wr(gpib_dev_pkg::REG_STB, 16'h0000);
		@(posedge sys_clk);
		`CHK("srq", 1'b0, srq_n_oe)
		wr(gpib_dev_pkg::REG_ADDR, 16'h0003);
		ctl.send(8'h3F, 1'b1, 1'b0);
		ctl.send(8'h23, 1'b1, 1'b0);
		rd(gpib_dev_pkg::REG_STATUS, d);
		`CHK("lsn", 1'b1, d[3])
		// interface clear drops both addressed states
		ifc_n <= 1'b0;
		@(posedge sys_clk);
		ifc_n <= 1'b1;
		rd(gpib_dev_pkg::REG_STATUS, d);
		`CHK("ifc", 2'b00, d[3:2])
		// reset in mid-run: address back to six, local again
		rstn <= 1'b0;
		@(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		`CHK("rst", 1'b0, keys_disabled)
		rchk(gpib_dev_pkg::REG_ADDR, 16'h0006);
		tally_and_finish();
	end
endmodule
